// [tb/sors_checker.sv]
// Checker: port assertions for the startup output release sequencer
`timescale 1ns/1ps
`default_nettype none
module sors_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Startup inputs
  input wire logic config_start,
  input wire logic internal_osc_tick,
  input wire logic oscillator_clock_input,
  input wire logic user_clock_edge,
  input wire logic cclk_pin_is_output,
  input wire logic cclk_pin_in,
  input wire logic done_line_input,
  // Startup outputs
  input wire logic done_out,
  input wire logic done_oe_n,
  input wire logic io_three_state,
  input wire logic config_pins_active,
  input wire logic cclk_pin_out
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic wr_pend;
  logic cmd_pend;
  logic cin_q;
  logic legal;
  logic [11:0] ctl;
  logic [3:0] cfg_age;
  logic [3:0] usr_age;
  logic [3:0] age;
  logic [2:0] pt;
  logic take;
  assign take = hsel && hready && htrans == 2'h2 && hwrite;
  assign pt = ctl[2:0];
  assign age = ctl[8] ? usr_age : cfg_age;
  // Legal release points per clock source and sync setting
  always_comb begin
    case (ctl[9:8])
      2'b10: legal = pt == 3'h1 || pt == 3'h2 || pt == 3'h4 || pt == 3'h5;
      2'b11: legal = pt == 3'h1 || (pt >= 3'h4 && pt <= 3'h6);
      default: legal = pt >= 3'h1 && pt <= 3'h3;
    endcase
  end
  // Shadow of the control word, since only the bus shows it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend <= 1'b0;
      cmd_pend <= 1'b0;
      ctl <= 12'h001;
    end else begin
      wr_pend <= take && haddr == 8'h00;
      cmd_pend <= take && haddr == 8'h08;
      if (wr_pend) begin
        ctl <= hwdata[11:0];
      end
    end
  end
  // Cycles since the latest startup edge of each kind, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cin_q <= 1'b0;
      cfg_age <= 4'hf;
      usr_age <= 4'hf;
    end else begin
      cin_q <= cclk_pin_in;
      cfg_age <= (cclk_pin_in && !cin_q) ? 4'h0 : cfg_age + {3'h0, cfg_age != 4'hf};
      usr_age <= user_clock_edge ? 4'h0 : usr_age + {3'h0, usr_age != 4'hf};
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  AST_PINS_INVERSE: assert property (config_pins_active == !io_three_state)
    else $error("config pins disagree with three-state");
  AST_RESTART: assert property ((config_start || (cmd_pend && hwdata[0])) |-> ##[1:2] io_three_state)
    else $error("restart did not three-state the outputs");
  AST_HOLD: assert property (!io_three_state && !config_start && !cmd_pend && !$past(cmd_pend)
    |=> !io_three_state)
    else $error("released outputs went back to three-state");
  AST_ILLEGAL: assert property (io_three_state && !legal |=> io_three_state)
    else $error("release at an illegal point");
  AST_DONE_RISE: assert property (ctl[9] && pt == 3'h4 && $rose(done_line_input)
    |-> ##[0:3] !io_three_state)
    else $error("no release on done line rise");
  AST_EDGE_ALIGNED: assert property ($fell(io_three_state) && pt <= 3'h3 |-> age <= 4'h4)
    else $error("release not at a startup edge");
  AST_DONE_PLUS: assert property ($fell(io_three_state) && pt >= 3'h5
    |-> $past(done_line_input) && age <= 4'h4)
    else $error("done plus release not after done and edge");
  AST_DONE_EDGE: assert property ($rose(done_oe_n) && (!ctl[8] || ctl[6:4] == 3'h0)
    |-> cfg_age <= 4'h4)
    else $error("done released away from a config edge");
  AST_OSC_TOGGLE: assert property (cclk_pin_is_output && (ctl[10] ? oscillator_clock_input :
    internal_osc_tick) |=> cclk_pin_out != $past(cclk_pin_out))
    else $error("config clock pin did not follow oscillator");
  AST_DONE_LOW: assert property (!done_out)
    else $error("done pin driven high");
endmodule // sors_checker
bind sors_sequencer sors_checker u_chk (
  .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .config_start(config_start), .internal_osc_tick(internal_osc_tick),
  .oscillator_clock_input(oscillator_clock_input), .user_clock_edge(user_clock_edge),
  .cclk_pin_is_output(cclk_pin_is_output), .cclk_pin_in(cclk_pin_in),
  .done_line_input(done_line_input), .done_out(done_out), .done_oe_n(done_oe_n),
  .io_three_state(io_three_state), .config_pins_active(config_pins_active),
  .cclk_pin_out(cclk_pin_out)
);
`default_nettype wire

// [tb/sors_done_partner.sv]
// Partner model: other devices sharing the open-drain done line
`timescale 1ns/1ps
`default_nettype none
module sors_done_partner #(
  parameter int settle = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench control and shared line
  input wire logic others_go,
  input wire logic dev_done_oe_n,
  output logic done_line
);
  int wait_cnt;
  logic others_rel;
  // Others pull low until all have configured, then let go after a settle delay
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_cnt <= 0;
      others_rel <= 1'b0;
    end else if (!others_go) begin
      wait_cnt <= 0;
      others_rel <= 1'b0;
    end else if (wait_cnt < settle) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      others_rel <= 1'b1;
    end
  end
  // Pull-up wins only when no party drives low
  assign done_line = dev_done_oe_n && others_rel;
endmodule // sors_done_partner
`default_nettype wire

// [tb/tb.sv]
// Testbench: self-checking bench for the startup output release sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, config_start = 1'b0;
  logic lcm = 1'b0, osc_tick = 1'b0, osc_in = 1'b0, usr = 1'b0, cout = 1'b0, cin = 1'b0;
  logic others_go = 1'b0, dpr = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q, seed = 32'hdec96be4;
  logic hreadyout, hresp, done_out, done_oe_n, io_ts, cpa, cclk_out, cclk_oe_n;
  wire logic done_line;
  int n_errors = 0, total_checks = 0, i;
  logic [11:0] cfgs [16] = '{12'h001, 12'h002, 12'h003, 12'h101, 12'h102, 12'h103, 12'h204,
    12'h205, 12'h304, 12'h305, 12'h306, 12'h004, 12'h303, 12'h206, 12'h801, 12'h023};
  always #5 clk = ~clk;
  sors_sequencer dut (.clk(clk), .reset(reset), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .config_start(config_start),
    .length_count_met(lcm), .done_pin_reached(dpr), .internal_osc_tick(osc_tick),
    .oscillator_clock_input(osc_in), .user_clock_edge(usr), .cclk_pin_is_output(cout),
    .cclk_pin_in(cin), .done_line_input(done_line), .done_out(done_out),
    .done_oe_n(done_oe_n), .io_three_state(io_ts), .config_pins_active(cpa),
    .cclk_pin_out(cclk_out), .cclk_pin_oe_n(cclk_oe_n));
  sors_done_partner #(.settle(3)) u_partner (.clk(clk), .reset(reset),
    .others_go(others_go), .dev_done_oe_n(done_oe_n), .done_line(done_line));
  // ****************************************************************
  // Helpers and reference model
  // ****************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic bit ok(input logic [11:0] c);
    int p;
    p = c[2:0];
    case (c[9:8])
      2'b10: return p inside {1, 2, 4, 5};
      2'b11: return p inside {1, 4, 5, 6};
      default: return p inside {1, 2, 3};
    endcase
  endfunction
  // Expected three-state level from startup edges and done events seen so far
  function automatic logic model(input logic [11:0] c, input int e, input bit dn, input int a);
    int p;
    p = c[2:0];
    if (!ok(c)) return 1'b1;
    if (p < 4) return !(e >= p + 1);
    if (p == 4) return !dn;
    return !(dn && a >= p - 4);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Bounded wait for the slave to be ready; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        tally_and_finish();
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic cfg_edge();
    seed = xorshift(seed);
    cin <= 1'b1;
    repeat (4 + seed[1:0]) @(posedge clk);
    cin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic usr_edge();
    seed = xorshift(seed);
    usr <= 1'b1;
    @(posedge clk);
    usr <= 1'b0;
    repeat (4 + seed[1:0]) @(posedge clk);
  endtask
  // One startup: four edges, then the shared done line, then two more edges
  task automatic run(input logic [11:0] c);
    int e, a;
    lcm <= 1'b0;
    others_go <= 1'b0;
    dpr <= !c[11];
    config_start <= 1'b1;
    @(posedge clk);
    config_start <= 1'b0;
    bus(1'b1, 8'h00, {20'h0, c});
    lcm <= 1'b1;
    @(posedge clk);
    // Done alignment: edges before the done pin is reached must not count
    if (c[11]) begin
      repeat (2) cfg_edge();
      check("length count waits for done pin", io_ts, 1'b1);
      dpr <= 1'b1;
      @(posedge clk);
    end
    if (c[8]) begin
      usr_edge();
      check("user edge before first config edge", io_ts, 1'b1);
      cfg_edge();
    end
    for (e = 1; e <= 4; e++) begin
      if (c[8]) usr_edge(); else cfg_edge();
      check("three-state per edge", io_ts, model(c, e, 0, 0));
      check("config pins", cpa, !model(c, e, 0, 0));
      check("done per edge", done_oe_n, e >= c[6:4] + 1);
    end
    others_go <= 1'b1;
    repeat (10) @(posedge clk);
    check("three-state on done rise", io_ts, model(c, 4, 1, 0));
    for (a = 1; a <= 2; a++) begin
      if (c[8]) usr_edge(); else cfg_edge();
      check("three-state after done", io_ts, model(c, 4 + a, 1, a));
    end
    bus(1'b0, 8'h04, 32'h0);
    check("status released", q[0], !model(c, 6, 1, 2));
    check("status illegal", q[2], !ok(c));
    check("status done", q[1], 1'b1);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("three-state after reset", io_ts, 1'b1);
    check("done held low", done_oe_n, 1'b0);
    bus(1'b0, 8'h00, 32'h0);
    check("ctrl reset value", q, 32'h0000_0001);
    seed = xorshift(seed);
    bus(1'b1, 8'h0c, seed);
    bus(1'b0, 8'h0c, 32'h0);
    check("unmapped read", q, 32'h0);
    for (i = 0; i < 16; i++) run(cfgs[i]);
    run(12'h001);
    lcm <= 1'b0;
    cfg_edge();
    check("stays released", io_ts, 1'b0);
    bus(1'b1, 8'h08, 32'h1);
    @(posedge clk);
    check("restart three-states", io_ts, 1'b1);
    // Oscillator strobes drive the config clock pin when it is an output
    cout <= 1'b1;
    for (i = 0; i < 4; i++) begin
      if (i == 2) bus(1'b1, 8'h00, 32'h0000_0401);
      q[0] = cclk_out;
      if (i < 2) osc_tick <= 1'b1; else osc_in <= 1'b1;
      @(posedge clk);
      osc_tick <= 1'b0;
      osc_in <= 1'b0;
      @(posedge clk);
      check("oscillator toggle", cclk_out, !q[0]);
      check("config clock driven", cclk_oe_n, 1'b0);
    end
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire

// [verilog/sors_ahb_slave.sv]
// AHB-Lite slave front end: address phase capture, always OKAY
`timescale 1ns/1ps
`default_nettype none
module sors_ahb_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  // Data phase
  output logic wr_valid,
  output logic rd_valid,
  output logic [7:0] phase_addr
);
  logic wr_pend;
  logic rd_pend;

  // Capture the address phase; only nonseq transfers count, and writes must also be whole-word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      phase_addr <= 8'h00;
    end else if (ce && hready) begin
      wr_pend <= hsel && htrans == sors_pkg::htrans_nonseq && hwrite
                 && hsize == sors_pkg::hsize_word;
      rd_pend <= hsel && htrans == sors_pkg::htrans_nonseq && !hwrite;
      phase_addr <= haddr;
    end
  end

  // Zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_valid = wr_pend && ce;
  assign rd_valid = rd_pend;
endmodule // sors_ahb_slave
`default_nettype wire

// [verilog/sors_edge_counter.sv]
// Saturating counter of startup clock edges
`timescale 1ns/1ps
`default_nettype none
module sors_edge_counter #(
  parameter int width = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Control
  input wire logic clear,
  input wire logic step,
  // Count
  output logic [width-1:0] count
);
  // Saturates so a long wait never wraps back onto a release point
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (ce) begin
      if (clear) begin
        count <= '0;
      end else if (step && count != {width{1'b1}}) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // sors_edge_counter
`default_nettype wire

// [verilog/sors_pkg.sv]
// Package: startup output release sequencer constants, types and register map
package sors_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] cmd_addr = 8'h08;

  // ****************************************************************
  // Control field positions and reset value
  // ****************************************************************
  localparam int ctrl_release_lsb = 0;   // 3 bits io_release_point
  localparam int ctrl_done_lsb = 4;      // 3 bits done_assert_point
  localparam int ctrl_clk_sel_bit = 8;   // startup_clock_select
  localparam int ctrl_sync_bit = 9;      // wait_for_done_line
  localparam int ctrl_osc_bit = 10;      // oscillator_source
  localparam int ctrl_lcm_bit = 11;      // length_count_method
  localparam logic [31:0] ctrl_reset = 32'h0000_0001;
  localparam int cmd_restart_bit = 0;    // Write one: new configuration

  // Status bit positions
  localparam int st_released_bit = 0;
  localparam int st_done_bit = 1;
  localparam int st_illegal_bit = 2;
  localparam int st_edge_lsb = 4;        // 3 bits edge count

  // ****************************************************************
  // Release and done point encodings
  // ****************************************************************
  localparam logic [2:0] pt_edge_one = 3'h0;
  localparam logic [2:0] pt_edge_two = 3'h1;
  localparam logic [2:0] pt_edge_three = 3'h2;
  localparam logic [2:0] pt_edge_four = 3'h3;
  localparam logic [2:0] pt_on_done_rise = 3'h4;
  localparam logic [2:0] pt_done_then_one_edge = 3'h5;
  localparam logic [2:0] pt_done_then_two_edges = 3'h6;

  localparam logic [2:0] edge_cnt_max = 3'h7;
  localparam logic [2:0] edge_cnt_zero = 3'h0;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;

  // Startup configuration bundle
  typedef struct packed {
    logic length_count_method;
    logic oscillator_source;
    logic wait_for_done_line;
    logic startup_clock_select;   // 0 configuration clock, 1 user clock
    logic ctrl_gap_hi;            // Spare bit so fields sit at their word positions
    logic [2:0] done_assert_point;
    logic ctrl_gap_lo;            // Spare bit between the two point fields
    logic [2:0] io_release_point;
  } sors_cfg_type;

  // Sequencer states
  typedef enum logic [3:0] {
    st_config = 4'b0001,
    st_count = 4'b0010,
    st_done_wait = 4'b0100,
    st_released = 4'b1000
  } sors_state_type;

endpackage

// [verilog/sors_sequencer.sv]
// Startup output release sequencer with AHB-Lite control registers
`timescale 1ns/1ps
`default_nettype none

module sors_sequencer (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration progress
  input wire logic config_start,
  input wire logic length_count_met,
  input wire logic done_pin_reached,
  // Startup clock qualifiers (synchronous edge strobes, plus config clock pin direction and level)
  input wire logic internal_osc_tick,
  input wire logic oscillator_clock_input,
  input wire logic user_clock_edge,
  input wire logic cclk_pin_is_output,
  input wire logic cclk_pin_in,
  // Shared done line
  input wire logic done_line_input,
  output logic done_out,
  output logic done_oe_n,
  // Release outputs
  output logic io_three_state,
  output logic config_pins_active,
  output logic cclk_pin_out,
  output logic cclk_pin_oe_n
);

  // ****************************************************************
  // Registers and bus
  // ****************************************************************
  sors_pkg::sors_cfg_type cfg;
  sors_pkg::sors_state_type state;
  sors_pkg::sors_state_type next_state;
  logic wr_valid;
  logic rd_valid;
  logic [7:0] phase_addr;
  logic restart_cmd;
  logic done_asserted;
  logic done_line_q;
  logic done_rise_seen;
  logic cclk_edge;
  logic startup_edge;
  logic first_cfg_edge_seen;
  logic count_step;
  logic [2:0] edge_count;
  logic [2:0] done_edge_count;
  logic release_hit;
  logic done_hit;
  logic point_illegal;
  logic lc_reached;
  logic osc_clock;
  logic cclk_q;

  sors_ahb_slave u_bus (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_valid(wr_valid),
    .rd_valid(rd_valid),
    .phase_addr(phase_addr)
  );

  // Control register write; defaults give config clock, edge two, no sync
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg <= sors_pkg::sors_cfg_type'(sors_pkg::ctrl_reset[11:0]);
    end else if (ce && wr_valid && phase_addr == sors_pkg::ctrl_addr) begin
      cfg <= sors_pkg::sors_cfg_type'(hwdata[11:0]);
    end
  end

  assign restart_cmd = wr_valid && phase_addr == sors_pkg::cmd_addr
                       && hwdata[sors_pkg::cmd_restart_bit];

  // Read data, registered; unmapped reads as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      unique case (haddr)
        sors_pkg::ctrl_addr: hrdata <= {20'h00000, cfg};
        sors_pkg::status_addr: hrdata <= {25'h0000000, edge_count, 1'b0,
                                          point_illegal, done_asserted,
                                          state == sors_pkg::st_released};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Startup clock selection
  // ****************************************************************
  // Oscillator source: internal tick or user clock on the osc input
  assign osc_clock = cfg.oscillator_source ? oscillator_clock_input
                                           : internal_osc_tick;

  // Config clock pin driven by the oscillator when the mode makes it an output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cclk_q <= 1'b0;
    end else if (ce && osc_clock) begin
      cclk_q <= ~cclk_q;
    end
  end
  assign cclk_pin_out = cclk_q;
  assign cclk_pin_oe_n = ~cclk_pin_is_output;

  // Config clock rising edge: own oscillator or the external pin level
  logic cclk_src_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cclk_src_q <= 1'b0;
    end else if (ce) begin
      cclk_src_q <= cclk_pin_is_output ? cclk_q : cclk_pin_in;
    end
  end
  assign cclk_edge = (cclk_pin_is_output ? cclk_q : cclk_pin_in) && !cclk_src_q;

  // Length count reached, by length or done alignment
  assign lc_reached = cfg.length_count_method ? (length_count_met && done_pin_reached)
                                              : length_count_met;

  // User edges count only after the first config edge past length count
  assign startup_edge = cfg.startup_clock_select
                        ? (user_clock_edge && first_cfg_edge_seen)
                        : cclk_edge;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      first_cfg_edge_seen <= 1'b0;
    end else if (ce) begin
      if (state != sors_pkg::st_count) begin
        first_cfg_edge_seen <= 1'b0;
      end else if (cclk_edge) begin
        first_cfg_edge_seen <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Edge counters
  // ****************************************************************
  // Counter idle once released, cleared by a new configuration
  assign count_step = startup_edge && state == sors_pkg::st_count;

  sors_edge_counter #(.width(3)) u_edges (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .clear(state == sors_pkg::st_config),
    .step(count_step),
    .count(edge_count)
  );

  // Edges after the done line rose, for the done-plus options
  sors_edge_counter #(.width(3)) u_done_edges (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .clear(!done_rise_seen),
    .step(startup_edge && state == sors_pkg::st_count),
    .count(done_edge_count)
  );

  // Done line rise detect; waiting devices hold it low meanwhile
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_line_q <= 1'b0;
      done_rise_seen <= 1'b0;
    end else if (ce) begin
      done_line_q <= done_line_input;
      if (state == sors_pkg::st_config) begin
        done_rise_seen <= 1'b0;
      end else if (done_line_input && !done_line_q) begin
        done_rise_seen <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Release point decode
  // ****************************************************************
  // Only the point set valid for this clock and sync choice is honoured
  always_comb begin
    point_illegal = 1'b0;
    release_hit = 1'b0;
    unique case (cfg.io_release_point)
      sors_pkg::pt_edge_two: begin
        release_hit = edge_count == 3'h2;
      end
      sors_pkg::pt_edge_three: begin
        release_hit = edge_count == 3'h3;
        point_illegal = cfg.wait_for_done_line && cfg.startup_clock_select;
      end
      sors_pkg::pt_edge_four: begin
        release_hit = edge_count == 3'h4;
        point_illegal = cfg.wait_for_done_line;
      end
      sors_pkg::pt_on_done_rise: begin
        release_hit = done_line_input;
        point_illegal = !cfg.wait_for_done_line;
      end
      sors_pkg::pt_done_then_one_edge: begin
        release_hit = done_rise_seen && done_edge_count >= 3'h1;
        point_illegal = !cfg.wait_for_done_line;
      end
      sors_pkg::pt_done_then_two_edges: begin
        release_hit = done_rise_seen && done_edge_count >= 3'h2;
        point_illegal = !(cfg.wait_for_done_line && cfg.startup_clock_select);
      end
      default: begin
        point_illegal = 1'b1;
      end
    endcase
    if (point_illegal) begin
      release_hit = 1'b0;
    end
  end

  // Done assert point: config edge one-four, or user edge two-four
  always_comb begin
    unique case (cfg.done_assert_point)
      sors_pkg::pt_edge_one: done_hit = cfg.startup_clock_select
                                        ? first_cfg_edge_seen : edge_count >= 3'h1;
      sors_pkg::pt_edge_two: done_hit = edge_count >= 3'h2;
      sors_pkg::pt_edge_three: done_hit = edge_count >= 3'h3;
      sors_pkg::pt_edge_four: done_hit = edge_count >= 3'h4;
      default: done_hit = edge_count >= 3'h1;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_asserted <= 1'b0;
    end else if (ce) begin
      // Set wins over a same-cycle restart; the config state clears it next
      if (done_hit && state != sors_pkg::st_config) begin
        done_asserted <= 1'b1;
      end else if (state == sors_pkg::st_config || restart_cmd) begin
        done_asserted <= 1'b0;
      end
    end
  end
  // Open drain: pull low until done, then let go
  assign done_out = 1'b0;
  assign done_oe_n = done_asserted;

  // ****************************************************************
  // State machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      sors_pkg::st_config: if (lc_reached) next_state = sors_pkg::st_count;
      sors_pkg::st_count: if (release_hit) next_state = sors_pkg::st_released;
      sors_pkg::st_done_wait: next_state = sors_pkg::st_count;
      sors_pkg::st_released: next_state = sors_pkg::st_released;
      default: next_state = sors_pkg::st_config;
    endcase
    if (config_start || restart_cmd) begin
      next_state = sors_pkg::st_config;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= sors_pkg::st_config;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Done-rise release acts at once, not one edge later
  assign io_three_state = !(state == sors_pkg::st_released
                            || (state == sors_pkg::st_count && release_hit
                                && cfg.io_release_point == sors_pkg::pt_on_done_rise));
  assign config_pins_active = !io_three_state;

endmodule // sors_sequencer
`default_nettype wire
